// ---- hw/dsirq_top.sv ----
`default_nettype none
module dsirq_top import dsirq_pkg::*; #(
  parameter int DATA_W = 16,
  parameter int NSRC = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic gyro_valid,
  input wire logic [2:0][DATA_W-1:0] gyro_data,
  input wire logic accel_valid,
  input wire logic [2:0][DATA_W-1:0] accel_data,
  input wire logic accel_active,
  input wire logic [NSRC-1:0] irq_sources,
  output logic gyro_out_valid,
  output logic [2:0][DATA_W-1:0] gyro_out,
  output logic gyro_queue_write,
  output logic accel_out_valid,
  output logic [2:0][DATA_W-1:0] accel_out,
  output logic accel_queue_write,
  output logic irq_pin_a_o,
  output logic irq_pin_a_oe_n,
  input wire logic irq_pin_b_i,
  output logic irq_pin_b_o,
  output logic irq_pin_b_oe_n,
  output logic ibi_request,
  output logic [7:0] ibi_feature
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (DATA_W < 2 || DATA_W > 32) begin : g_bad_width
    $error("DATA_W must lie between 2 and 32");
  end
  if (NSRC != 7) begin : g_bad_src
    $error("NSRC must be 7 to fit the route registers");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [7:0] wdata;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] mode;
    logic trig_pol;
    logic [4:0] stamp_sel;
    logic [7:0] route_a;
    logic [NSRC-1:0] route_b;
    logic [1:0] pin_beh;
    logic prev_active;
    logic win_even;
    logic [2:0][DATA_W-1:0] gyro_q;
    logic gyro_v;
    logic gyro_wr;
    logic [2:0][DATA_W-1:0] accel_q;
    logic accel_v;
    logic accel_wr;
    logic ready_pulse;
    logic pin_a_on;
    logic pin_b_on;
    logic [NSRC-1:0] src_prev;
    logic ibi_req;
    logic [7:0] ibi_feat;
  } dsirq_state_t;

  dsirq_state_t st_r;
  dsirq_state_t st_nxt;
  logic trig_level;
  logic active;
  logic tick;
  logic rise;
  logic latched;
  logic queue_gate;
  logic [NSRC-1:0] src_gated;
  logic [NSRC-1:0] src_new;
  logic win_even_now;
  logic w_fire;
  logic [31:0] rd_word;
  logic rd_ok;

  dsirq_sync u_trig_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_i(irq_pin_b_i),
    .level_o(trig_level)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Replaces the LSB of each selected axis; x, y, z sit at index 0, 1, 2.
  function automatic logic [2:0][DATA_W-1:0] stamp_axes(
    input logic [2:0][DATA_W-1:0] d,
    input logic [4:0] sel,
    input logic en,
    input logic val
  );
    logic [2:0][DATA_W-1:0] r;
    r = d;
    if (en && sel[STAMP_AXIS_X_BIT]) begin
      r[0][0] = val;
    end
    if (en && sel[STAMP_AXIS_Y_BIT]) begin
      r[1][0] = val;
    end
    if (en && sel[STAMP_AXIS_Z_BIT]) begin
      r[2][0] = val;
    end
    return r;
  endfunction

  function automatic logic [31:0] read_reg(input dsirq_state_t s, input logic [7:0] a,
                                           input logic [NSRC-1:0] src, input logic lvl);
    logic [31:0] r;
    r = 32'h0;
    if (a == TRIGGER_MODE_CONTROL_OFS) begin
      r[2:0] = s.mode;
    end else if (a == MISC_CONTROL_OFS) begin
      r[0] = s.trig_pol;
    end else if (a == STAMP_SELECT_CONTROL_OFS) begin
      r[4:0] = s.stamp_sel;
    end else if (a == PIN_A_ROUTE_CONTROL_OFS) begin
      r[7:0] = s.route_a;
    end else if (a == PIN_B_ROUTE_CONTROL_OFS) begin
      r[NSRC-1:0] = s.route_b;
    end else if (a == PIN_BEHAVIOUR_CONTROL_OFS) begin
      r[1:0] = s.pin_beh;
    end else if (a == SOURCE_STATUS_OFS) begin
      r[NSRC-1:0] = src;
      r[8] = lvl;
      r[9] = s.win_even;
    end else if (a == IBI_FEATURE_OFS) begin
      r[7:0] = s.ibi_feat;
    end
    return r;
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= IBI_FEATURE_OFS;
  endfunction

  // ----------------------------------------------------------------
  // Trigger detection
  // ----------------------------------------------------------------
  // Trigger polarity: active low unless the polarity bit is set.
  // polarity of trigger
  assign active = st_r.trig_pol ? trig_level : ~trig_level;
  // Both sensors run at one rate in the trigger modes, so either strobe marks a period.
  // shared rate assumed
  assign tick = gyro_valid | accel_valid;
  assign rise = tick & active & ~st_r.prev_active;
  assign latched = st_r.mode == MODE_LATCHED;
  assign queue_gate = st_r.mode == MODE_QUEUE_GATE;
  // Each window toggles the parity; the first window after reset is odd.
  // window parity
  assign win_even_now = (queue_gate && rise) ? ~st_r.win_even : st_r.win_even;
  assign src_gated = {irq_sources[NSRC-1:SRC_MOTION_LO] & {(NSRC-SRC_MOTION_LO){accel_active}},
                      irq_sources[SRC_MOTION_LO-1:0]};
  assign src_new = src_gated & ~st_r.src_prev & (st_r.route_a[NSRC-1:0] | st_r.route_b);
  assign w_fire = st_r.aw_held && st_r.w_held && !st_r.bvalid;
  assign rd_word = read_reg(st_r, s_axi_araddr, src_gated, trig_level);
  assign rd_ok = reg_mapped(s_axi_araddr);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic gyro_cov;
    logic accel_cov;
    logic stamp_on;
    logic stamp_val;
    logic pulse;
    gyro_cov = 1'b1;
    accel_cov = st_r.stamp_sel[TRIGGER_ACCEL_EXTEND_BIT];
    stamp_on = latched | queue_gate;
    stamp_val = 1'b0;
    pulse = 1'b0;
    st_nxt = st_r;
    // AXI write: address and data are taken in either order.
    if (s_axi_awvalid && !st_r.aw_held) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_held) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = s_axi_wdata[7:0];
      st_nxt.wlane = s_axi_wstrb[0];
    end
    if (w_fire) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = reg_mapped(st_r.awaddr) ? AXI_OKAY : AXI_SLVERR;
      if (st_r.wlane) begin
        if (st_r.awaddr == TRIGGER_MODE_CONTROL_OFS) begin
          st_nxt.mode = st_r.wdata[2:0];
        end else if (st_r.awaddr == MISC_CONTROL_OFS) begin
          st_nxt.trig_pol = st_r.wdata[0];
        end else if (st_r.awaddr == STAMP_SELECT_CONTROL_OFS) begin
          st_nxt.stamp_sel = st_r.wdata[4:0];
        end else if (st_r.awaddr == PIN_A_ROUTE_CONTROL_OFS) begin
          st_nxt.route_a = st_r.wdata;
        end else if (st_r.awaddr == PIN_B_ROUTE_CONTROL_OFS) begin
          st_nxt.route_b = st_r.wdata[NSRC-1:0];
        end else if (st_r.awaddr == PIN_BEHAVIOUR_CONTROL_OFS) begin
          st_nxt.pin_beh = st_r.wdata[1:0];
        end
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // AXI read: one outstanding, data registered.
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // The level seen at a data update is final for that period.
    // sample at update
    if (tick) begin
      st_nxt.prev_active = active;
    end
    st_nxt.win_even = win_even_now;
    if (latched) begin
      stamp_val = rise;
    end else if (queue_gate) begin
      stamp_val = win_even_now;
    end
    st_nxt.gyro_v = gyro_valid;
    if (gyro_valid) begin
      st_nxt.gyro_q = stamp_axes(gyro_data, st_r.stamp_sel,
                                 stamp_on && gyro_cov && !st_r.stamp_sel[STAMP_SENSOR_SELECT_BIT],
                                 stamp_val);
    end
    st_nxt.accel_v = accel_valid;
    if (accel_valid) begin
      st_nxt.accel_q = stamp_axes(accel_data, st_r.stamp_sel,
                                  stamp_on && accel_cov && st_r.stamp_sel[STAMP_SENSOR_SELECT_BIT],
                                  stamp_val);
    end
    st_nxt.gyro_wr = gyro_valid && (!(queue_gate && gyro_cov) || active);
    st_nxt.accel_wr = accel_valid && (!(queue_gate && accel_cov) || active);
    // The pulse lines up with the output valid of the stamped sample.
    // gated ready pulse
    pulse = latched && st_r.route_a[GATED_READY_ROUTE_BIT] && rise;
    st_nxt.ready_pulse = pulse;
    // Sources OR together on each pin.
    // independent routing
    st_nxt.pin_a_on = |(src_gated & st_r.route_a[NSRC-1:0]) | pulse;
    st_nxt.pin_b_on = |(src_gated & st_r.route_b);
    st_nxt.src_prev = src_gated;
    st_nxt.ibi_req = (|src_new) | pulse;
    if ((|src_new) || pulse) begin
      st_nxt.ibi_feat = {pulse, src_new};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.mode <= TRIGGER_MODE_RESET;
      st_r.stamp_sel <= STAMP_SELECT_RESET;
      st_r.win_even <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !st_r.aw_held;
  assign s_axi_wready = !st_r.w_held;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign gyro_out_valid = st_r.gyro_v;
  assign gyro_out = st_r.gyro_q;
  assign gyro_queue_write = st_r.gyro_wr;
  assign accel_out_valid = st_r.accel_v;
  assign accel_out = st_r.accel_q;
  assign accel_queue_write = st_r.accel_wr;
  assign ibi_request = st_r.ibi_req;
  assign ibi_feature = st_r.ibi_feat;
  assign irq_pin_a_o = st_r.pin_a_on ^ st_r.pin_beh[IRQ_POLARITY_SELECT_BIT];
  assign irq_pin_b_o = st_r.pin_b_on ^ st_r.pin_beh[IRQ_POLARITY_SELECT_BIT];
  // Open drain releases the pin whenever it is not asserted.
  // output type
  assign irq_pin_a_oe_n = st_r.pin_beh[IRQ_OUTPUT_TYPE_BIT] & ~st_r.pin_a_on;
  // Pin B becomes the trigger input in every trigger mode.
  // pin B as input
  assign irq_pin_b_oe_n = (st_r.mode != MODE_OFF) |
                          (st_r.pin_beh[IRQ_OUTPUT_TYPE_BIT] & ~st_r.pin_b_on);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_stamped_gyro_x;
    gyro_out_valid && gyro_out[0][0] && $past(latched) &&
    $past(st_r.stamp_sel[STAMP_AXIS_X_BIT]) && !$past(st_r.stamp_sel[STAMP_SENSOR_SELECT_BIT]);
  endsequence

  sequence s_window_flip;
    $past(queue_gate) && $changed(st_r.win_even);
  endsequence

  latch_stamp_once_a: assert property (s_stamped_gyro_x |-> st_r.prev_active &&
    !$past(st_r.prev_active)) else $error("latched stamp without fresh trigger");
  ready_pulse_sample_a: assert property (st_r.ready_pulse |->
    (gyro_out_valid || accel_out_valid) && st_r.pin_a_on) else $error("pulse without sample");
  queue_gate_a: assert property ($past(queue_gate) && gyro_queue_write |->
    st_r.prev_active) else $error("queue write outside active window");
  window_toggle_a: assert property (s_window_flip |->
    st_r.prev_active && !$past(st_r.prev_active)) else $error("parity moved without event");
  stamp_reset_a: assert property ($rose(aresetn) |->
    st_r.stamp_sel == STAMP_SELECT_RESET) else $error("stamp selection reset wrong");
  motion_gate_a: assert property (!accel_active |->
    src_gated[NSRC-1:SRC_MOTION_LO] == '0) else $error("motion source without accelerometer");
  idle_level_a: assert property (!st_r.pin_a_on && !irq_pin_a_oe_n |->
    irq_pin_a_o == st_r.pin_beh[IRQ_POLARITY_SELECT_BIT]) else $error("idle level wrong");
  open_drain_a: assert property (st_r.pin_beh[IRQ_OUTPUT_TYPE_BIT] && !st_r.pin_a_on |->
    irq_pin_a_oe_n) else $error("open drain drives idle state");
  pin_b_input_a: assert property (st_r.mode != MODE_OFF |-> irq_pin_b_oe_n)
    else $error("pin B driven in trigger mode");
  ibi_report_a: assert property (|src_new |=> ibi_request &&
    ibi_feature[NSRC-1:0] == $past(src_new)) else $error("in-band feature not reported");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
endmodule
`default_nettype wire

// ---- hw/dsirq_pkg.sv ----
`default_nettype none
package dsirq_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TRIGGER_MODE_CONTROL_OFS = 8'h00;
  localparam logic [7:0] MISC_CONTROL_OFS = 8'h04;
  localparam logic [7:0] STAMP_SELECT_CONTROL_OFS = 8'h08;
  localparam logic [7:0] PIN_A_ROUTE_CONTROL_OFS = 8'h0c;
  localparam logic [7:0] PIN_B_ROUTE_CONTROL_OFS = 8'h10;
  localparam logic [7:0] PIN_BEHAVIOUR_CONTROL_OFS = 8'h14;
  localparam logic [7:0] SOURCE_STATUS_OFS = 8'h18;
  localparam logic [7:0] IBI_FEATURE_OFS = 8'h1c;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LATCH_MODE_SELECT_BIT = 0;
  localparam int LEVEL_MODE_SELECT_BIT = 1;
  localparam int EDGE_TRIGGER_SELECT_BIT = 2;
  localparam int STAMP_SENSOR_SELECT_BIT = 0;
  localparam int STAMP_AXIS_Z_BIT = 1;
  localparam int STAMP_AXIS_Y_BIT = 2;
  localparam int STAMP_AXIS_X_BIT = 3;
  localparam int TRIGGER_ACCEL_EXTEND_BIT = 4;
  localparam int GATED_READY_ROUTE_BIT = 7;
  localparam int IRQ_POLARITY_SELECT_BIT = 0;
  localparam int IRQ_OUTPUT_TYPE_BIT = 1;
  localparam int SRC_MOTION_LO = 5;
  // ----------------------------------------------------------------
  // Mode codes {edge, level, latch}
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_LATCHED = 3'h3;
  localparam logic [2:0] MODE_QUEUE_GATE = 3'h6;
  // ----------------------------------------------------------------
  // Reset values and AXI response codes
  // ----------------------------------------------------------------
  localparam logic [4:0] STAMP_SELECT_RESET = 5'h0e;
  localparam logic [2:0] TRIGGER_MODE_RESET = 3'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- hw/dsirq_sync.sv ----
`default_nettype none
module dsirq_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_i,
  output logic level_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } dsirq_sync_t;

  dsirq_sync_t st_r;
  dsirq_sync_t st_nxt;

  // A change is taken only once the second and third stages agree.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.level = st_r.s3;
    end
  end

  // All stages reset high, the inactive level of the default active-low trigger.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.level;
endmodule
`default_nettype wire

// ---- verification/dsirq_sense_model.sv ----
`default_nettype none
module dsirq_sense_model #(
  parameter int PERIOD = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic trig_level,
  input wire logic pin_b_o,
  input wire logic pin_b_oe_n,
  output logic pin_b,
  output logic tick,
  output logic [2:0][15:0] gyro_data,
  output logic [2:0][15:0] accel_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_r;
  logic par_r;
  // trigger on pin B
  // The source drives pin B only while the device has let go of it.
  assign pin_b = pin_b_oe_n ? trig_level : pin_b_o;
  // one shared rate
  // Both sensors share one strobe, so they always run at the same output data rate.
  assign tick = aresetn && (cnt_r == 8'(PERIOD - 1));
  // batching limits
  // Every strobe is one whole sample with no decimation, as the queue limits demand.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 8'h00;
      par_r <= 1'b0;
    end else begin
      cnt_r <= tick ? 8'h00 : cnt_r + 8'h01;
      if (cnt_r == 8'(PERIOD / 2)) begin
        par_r <= !par_r;
      end
    end
  end
  // The raw LSB flips between samples so that a missing stamp shows either way.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      gyro_data[i] = {4'(i + 1), 11'h0a5, par_r};
      accel_data[i] = {4'(i + 5), 11'h05a, par_r};
    end
  end
endmodule
`default_nettype wire

// ---- verification/dsirq_tb_top.sv ----
`default_nettype none
module dsirq_tb_top import dsirq_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, trig, accel_active, pin_b, tick;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ibi_feature;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [6:0] irq_sources;
  logic gyro_out_valid, gyro_queue_write, accel_out_valid, accel_queue_write, ibi_request;
  logic [2:0][15:0] gyro_out, accel_out, gdat, adat;
  logic irq_pin_a_o, irq_pin_a_oe_n, irq_pin_b_o, irq_pin_b_oe_n;
  int bad_count = 0;
  int checks_done = 0;

  dsirq_top dsirq_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .gyro_valid(tick), .gyro_data(gdat), .accel_valid(tick),
    .accel_data(adat), .accel_active, .irq_sources, .gyro_out_valid, .gyro_out,
    .gyro_queue_write, .accel_out_valid, .accel_out, .accel_queue_write, .irq_pin_a_o,
    .irq_pin_a_oe_n, .irq_pin_b_i(pin_b), .irq_pin_b_o, .irq_pin_b_oe_n, .ibi_request,
    .ibi_feature);
  dsirq_sense_model dsirq_sense_model_i (.aclk, .aresetn, .trig_level(trig),
    .pin_b_o(irq_pin_b_o), .pin_b_oe_n(irq_pin_b_oe_n), .pin_b, .tick, .gyro_data(gdat),
    .accel_data(adat));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw, w;
    int n;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      // Ready rises only once the response is up, so the slave must hold it a cycle.
      if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        chk("bresp", 48'(er), 48'(s_axi_bresp));
        break;
      end else if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b1;
      end
    end
    if (n == 50) chk("write done", 48'h1, 48'h0);
  endtask

  // Only the low byte is compared: status bits above it follow the pin and window state.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        chk("rdata", 48'(e), 48'(s_axi_rdata[7:0]));
        chk("rresp", 48'(er), 48'(s_axi_rresp));
        break;
      end
    end
    if (n == 50) chk("read done", 48'h1, 48'h0);
  endtask

  // The pin level is ignored where the pin is expected to be released.
  task automatic pins(input logic ao, input logic ae, input logic bo, input logic be);
    #1;
    chk("pin_a", 48'({ae ? 1'b0 : ao, ae}), 48'({ae ? 1'b0 : irq_pin_a_o, irq_pin_a_oe_n}));
    chk("pin_b", 48'({be ? 1'b0 : bo, be}), 48'({be ? 1'b0 : irq_pin_b_o, irq_pin_b_oe_n}));
  endtask

  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask

  task automatic smp(input logic sel, input logic [2:0] m, input logic st, input logic gq,
                     input logic aq);
    logic [2:0][15:0] eg, ea;
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      #1;
      if (gyro_out_valid === 1'b1) break;
    end
    eg = gdat;
    ea = adat;
    for (int i = 0; i < 3; i++) begin
      if (m[i] && sel) ea[i][0] = st;
      if (m[i] && !sel) eg[i][0] = st;
    end
    chk("out valid", 48'h3, 48'({gyro_out_valid, accel_out_valid}));
    chk("queue writes", 48'({gq, aq}), 48'({gyro_queue_write, accel_queue_write}));
    if (gq || aq) begin
      chk("gyro_out", eg, gyro_out);
      chk("accel_out", ea, accel_out);
    end
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    trig = 1'b1;
    accel_active = 1'b0;
    irq_sources = 7'h00;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // ----------------------------------------------------------------
    // Reset state and bus refusals
    // ----------------------------------------------------------------
    rchk(STAMP_SELECT_CONTROL_OFS, 8'h0e, AXI_OKAY);
    rchk(8'h20, 8'h00, AXI_SLVERR);
    wr(8'h24, 32'h1, 4'hf, AXI_SLVERR);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    wr(TRIGGER_MODE_CONTROL_OFS, 32'h3, 4'h0, AXI_OKAY);
    rchk(TRIGGER_MODE_CONTROL_OFS, 8'h00, AXI_OKAY);
    // ----------------------------------------------------------------
    // Latched mode, trigger active low
    // ----------------------------------------------------------------
    wr(TRIGGER_MODE_CONTROL_OFS, 32'h3, 4'hf, AXI_OKAY);
    wr(PIN_A_ROUTE_CONTROL_OFS, 32'h80, 4'hf, AXI_OKAY);
    smp(1'b0, 3'h7, 1'b0, 1'b1, 1'b1);
    smp(1'b0, 3'h7, 1'b0, 1'b1, 1'b1);
    repeat (14) @(posedge aclk);
    trig <= 1'b0;
    smp(1'b0, 3'h7, 1'b0, 1'b1, 1'b1);
    smp(1'b0, 3'h7, 1'b1, 1'b1, 1'b1);
    pins(1'b1, 1'b0, 1'b0, 1'b1);
    chk("ibi", 48'h180, 48'({ibi_request, ibi_feature}));
    @(posedge aclk) trig <= 1'b1;
    smp(1'b0, 3'h7, 1'b0, 1'b1, 1'b1);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    // ----------------------------------------------------------------
    // Queue gating, trigger active high, stamp on accelerometer z
    // ----------------------------------------------------------------
    @(posedge aclk) trig <= 1'b0;
    wr(MISC_CONTROL_OFS, 32'h1, 4'hf, AXI_OKAY);
    wr(STAMP_SELECT_CONTROL_OFS, 32'h13, 4'hf, AXI_OKAY);
    wr(TRIGGER_MODE_CONTROL_OFS, 32'h6, 4'hf, AXI_OKAY);
    smp(1'b1, 3'h4, 1'b0, 1'b0, 1'b0);
    for (int w = 0; w < 2; w++) begin
      @(posedge aclk) trig <= 1'b1;
      smp(1'b1, 3'h4, w[0], 1'b1, 1'b1);
      smp(1'b1, 3'h4, w[0], 1'b1, 1'b1);
      @(posedge aclk) trig <= 1'b0;
      smp(1'b1, 3'h4, 1'b0, 1'b0, 1'b0);
    end
    // ----------------------------------------------------------------
    // Interrupt routing, polarity and output type
    // ----------------------------------------------------------------
    wr(TRIGGER_MODE_CONTROL_OFS, 32'h0, 4'hf, AXI_OKAY);
    wr(PIN_A_ROUTE_CONTROL_OFS, 32'h21, 4'hf, AXI_OKAY);
    wr(PIN_B_ROUTE_CONTROL_OFS, 32'h04, 4'hf, AXI_OKAY);
    wr(PIN_BEHAVIOUR_CONTROL_OFS, 32'h3, 4'hf, AXI_OKAY);
    @(posedge aclk) irq_sources <= 7'h20;
    settle();
    pins(1'b0, 1'b1, 1'b0, 1'b1);
    rchk(SOURCE_STATUS_OFS, 8'h00, AXI_OKAY);
    @(posedge aclk) accel_active <= 1'b1;
    settle();
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    rchk(SOURCE_STATUS_OFS, 8'h20, AXI_OKAY);
    @(posedge aclk) irq_sources <= 7'h04;
    settle();
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    chk("ibi_feature", 48'h04, 48'(ibi_feature));
    rchk(SOURCE_STATUS_OFS, 8'h04, AXI_OKAY);
    wr(PIN_BEHAVIOUR_CONTROL_OFS, 32'h0, 4'hf, AXI_OKAY);
    settle();
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    summarize();
  end

  initial begin
    repeat (4000) @(posedge aclk);
    bad_count++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    summarize();
  end
endmodule
`default_nettype wire
